// File: logic/hpcfg_defs.svh
// Offsets, field positions, reset values and timing counts for host pad configuration
//
// Contract
// - Writing one then zero to the arm bit, at least one slow oscillator cycle apart, turns supply-loss detection on.
// - The same one-then-zero sequence on the disarm bit turns supply-loss detection off.
// - A pull field of 00b means pull-down, 01b no pull, 10b bus keeper and 11b pull-up.
// - Bit 16 of the interrupt pad register hands the interrupt pin to the interrupt unit output.
// - Bit 1 of each pad register switches that pad's output driver and resets to zero.
// - Bit 0 of each pad register switches that pad's input driver; it resets to one only for host data.
// - Bits 5 to 4 of each pad register hold a writable drive selection that resets to zero.
// - The host data pull field resets to 11b, pull-up.
// - The interrupt pull field resets to 00b, pull-down.
`ifndef HPCFG_DEFS_SVH
`define HPCFG_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define HPCFG_OFS_DISARM     8'haf
`define HPCFG_OFS_ARM        8'hb0
`define HPCFG_OFS_DL_PAD     8'hb1
`define HPCFG_OFS_IRQ_PAD    8'hb2
`define HPCFG_OFS_HD_PAD     8'hb3
`define HPCFG_OFS_STATUS     8'hbf

// ----------------------------------------------------------------
// Field positions, masks and reset values
// ----------------------------------------------------------------
`define HPCFG_BIT_IN_EN      0
`define HPCFG_BIT_OUT_EN     1
`define HPCFG_LSB_PULL       2
`define HPCFG_LSB_DRIVE      4
`define HPCFG_BIT_IRQ_ROUTE  16
`define HPCFG_MASK_PAD       32'h0000_003f
`define HPCFG_MASK_IRQ_PAD   32'h0001_003f
`define HPCFG_RST_DL_PAD     32'h0000_0000
`define HPCFG_RST_IRQ_PAD    32'h0000_0000
`define HPCFG_RST_HD_PAD     32'h0000_000d

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define HPCFG_LFO_MIN_CYCLES 1

`endif

// File: logic/hpcfg_pkg.sv
// Types shared by the host pad configuration block
package hpcfg_pkg;

    // Pull modes of a pad
    typedef enum logic [1:0] {
        HPCFG_PULL_DOWN = 2'h0,
        HPCFG_PULL_NONE = 2'h1,
        HPCFG_PULL_KEEP = 2'h2,
        HPCFG_PULL_UP   = 2'h3
    } hpcfg_pull_t;

    // Write-pulse sequencer states, Gray along idle, high, ready
    typedef enum logic [1:0] {
        HPCFG_SEQ_IDLE  = 2'b00,
        HPCFG_SEQ_HIGH  = 2'b01,
        HPCFG_SEQ_READY = 2'b11
    } hpcfg_seq_t;

endpackage : hpcfg_pkg

// File: logic/hpcfg_seq.sv
// One-then-zero write sequencer qualified by slow oscillator edges
`timescale 1ns/1ns
`default_nettype none
`include "hpcfg_defs.svh"

module hpcfg_seq
    import hpcfg_pkg::*;
#(
    parameter int unsigned MIN_LFO_CYCLES = `HPCFG_LFO_MIN_CYCLES
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // Software writes and slow edge
    input  wire logic wr_one,
    input  wire logic wr_zero,
    input  wire logic lfo_rise,
    // Results
    output logic      bit_q,
    output logic      ready,
    output logic      done
);

    // One edge may land just after the write, so a full cycle needs one more
    localparam int unsigned EDGES = MIN_LFO_CYCLES + 1;
    localparam int unsigned CW    = $clog2(EDGES + 1);

    hpcfg_seq_t    state_reg;
    hpcfg_seq_t    state_next;
    logic [CW-1:0] edge_reg;
    logic          bit_reg;
    logic          done_reg;

    // Next state of the sequence
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            HPCFG_SEQ_IDLE: begin
                if (wr_one) state_next = HPCFG_SEQ_HIGH;
            end
            HPCFG_SEQ_HIGH: begin
                if (wr_one) state_next = HPCFG_SEQ_HIGH;
                else if (wr_zero) state_next = HPCFG_SEQ_IDLE;
                else if (lfo_rise && edge_reg == CW'(EDGES - 1)) state_next = HPCFG_SEQ_READY;
            end
            HPCFG_SEQ_READY: begin
                if (wr_one) state_next = HPCFG_SEQ_HIGH;
                else if (wr_zero) state_next = HPCFG_SEQ_IDLE;
            end
            default: state_next = HPCFG_SEQ_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (rst) state_reg <= HPCFG_SEQ_IDLE;
        else state_reg <= state_next;
    end

    // Slow edge count, restarted by every one-write
    always_ff @(posedge clk_sys) begin
        if (rst || wr_one) edge_reg <= '0;
        else if (state_reg == HPCFG_SEQ_HIGH && lfo_rise) edge_reg <= edge_reg + CW'(1);
    end

    // Stored bit as software sees it
    always_ff @(posedge clk_sys) begin
        if (rst) bit_reg <= 1'b0;
        else if (wr_one) bit_reg <= 1'b1;
        else if (wr_zero) bit_reg <= 1'b0;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) done_reg <= 1'b0;
        else done_reg <= wr_zero && state_reg == HPCFG_SEQ_READY;
    end

    assign bit_q = bit_reg;
    assign ready = state_reg == HPCFG_SEQ_READY;
    assign done  = done_reg;

    // Completion only after a qualified high phase
    seq_done_cause_a: assert property (@(posedge clk_sys) disable iff (rst)
        done |-> $past(wr_zero) && $past(state_reg) == HPCFG_SEQ_READY)
        else $error("sequence completed without a qualified zero write");

    // A zero written too early completes nothing and returns to idle
    seq_early_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
        (state_reg == HPCFG_SEQ_HIGH && wr_zero) |=> !done && state_reg == HPCFG_SEQ_IDLE)
        else $error("early zero write was accepted");

endmodule : hpcfg_seq
`default_nettype wire

// File: logic/hpcfg_top.sv
// Host pad configuration registers, pin control and supply-loss arming
//
// Local design decision: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "hpcfg_defs.svh"

module hpcfg_top
    import hpcfg_pkg::*;
#(
    parameter int unsigned MIN_LFO_CYCLES = `HPCFG_LFO_MIN_CYCLES
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Register port
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wr_data,
    input  wire logic        wr_stb,
    input  wire logic        rd_stb,
    output logic      [31:0] rd_data,
    // Slow oscillator, sampled as a level
    input  wire logic        low_freq_osc,
    // Analog power unit control
    output logic             supply_loss_arm_bit,
    output logic             supply_loss_disarm_bit,
    output logic             supply_loss_det_on,
    // Core side of the pads: 0 download, 1 interrupt, 2 host data
    input  wire logic [2:0]  gpio_out,
    output logic      [2:0]  gpio_in,
    input  wire logic        irq_unit_out,
    // Download request pin
    input  wire logic        download_request_pin_i,
    output logic             download_request_pin_o,
    output logic             download_request_pin_oe_n,
    // Interrupt request pin
    input  wire logic        interrupt_pin_i,
    output logic             interrupt_pin_o,
    output logic             interrupt_pin_oe_n,
    // Host data pin
    input  wire logic        host_data_pin_i,
    output logic             host_data_pin_o,
    output logic             host_data_pin_oe_n,
    // Pad drive selections
    output logic      [1:0]  download_drive_sel,
    output logic      [1:0]  interrupt_drive_sel,
    output logic      [1:0]  host_data_drive_sel,
    // Pad pull selections, raw and decoded
    output logic      [1:0]  download_pull_sel,
    output logic      [1:0]  interrupt_pull_sel,
    output logic      [1:0]  host_data_pull_sel,
    output logic      [2:0]  pad_pull_down,
    output logic      [2:0]  pad_pull_up,
    output logic      [2:0]  pad_keeper,
    // Pad driver enables
    output logic             download_out_en,
    output logic             download_in_en,
    output logic             interrupt_out_en,
    output logic             interrupt_in_en,
    output logic             host_data_out_en,
    output logic             host_data_in_en,
    output logic             interrupt_route
);

    // ----------------------------------------------------------------
    // Pad tables
    // ----------------------------------------------------------------
    localparam int unsigned PADS = 3;
    localparam logic [7:0]  PAD_OFS  [PADS] = '{`HPCFG_OFS_DL_PAD, `HPCFG_OFS_IRQ_PAD,
                                                `HPCFG_OFS_HD_PAD};
    localparam logic [31:0] PAD_MASK [PADS] = '{`HPCFG_MASK_PAD, `HPCFG_MASK_IRQ_PAD,
                                                `HPCFG_MASK_PAD};
    localparam logic [31:0] PAD_RST  [PADS] = '{`HPCFG_RST_DL_PAD, `HPCFG_RST_IRQ_PAD,
                                                `HPCFG_RST_HD_PAD};

    // Pull field decode, used by every pad
    function automatic logic [2:0] pull_decode(input logic [1:0] sel);
        hpcfg_pull_t mode;
        mode = hpcfg_pull_t'(sel);
        case (mode)
            HPCFG_PULL_DOWN: pull_decode = 3'b001;
            HPCFG_PULL_NONE: pull_decode = 3'b000;
            HPCFG_PULL_KEEP: pull_decode = 3'b100;
            HPCFG_PULL_UP:   pull_decode = 3'b010;
            default:         pull_decode = 3'b000;
        endcase
    endfunction : pull_decode

    // ----------------------------------------------------------------
    // Internal signals
    // ----------------------------------------------------------------
    logic [31:0] pad_reg   [PADS];
    logic [PADS-1:0] pin_i;
    logic [PADS-1:0] pin_o_reg;
    logic [PADS-1:0] oe_n_reg;
    logic [PADS-1:0] in_reg;
    logic [PADS-1:0] src;
    logic [31:0] rd_next;
    logic [31:0] rd_reg;
    logic        lfo_prev_reg;
    logic        lfo_rise;
    logic        det_on_reg;
    logic        wr_arm;
    logic        wr_disarm;
    logic        arm_ready;
    logic        arm_done;
    logic        disarm_ready;
    logic        disarm_done;

    assign pin_i = {host_data_pin_i, interrupt_pin_i, download_request_pin_i};

    // ----------------------------------------------------------------
    // Pad configuration registers and pin paths
    // ----------------------------------------------------------------
    for (genvar p = 0; p < PADS; p++) begin : g_pad
        logic [2:0] pull_vec;

        always_ff @(posedge clk_sys) begin
            if (rst) pad_reg[p] <= PAD_RST[p];
            else if (wr_stb && addr == PAD_OFS[p]) pad_reg[p] <= wr_data & PAD_MASK[p];
        end

        assign pull_vec         = pull_decode(pad_reg[p][`HPCFG_LSB_PULL+:2]);
        assign pad_pull_down[p] = pull_vec[0];
        assign pad_pull_up[p]   = pull_vec[1];
        assign pad_keeper[p]    = pull_vec[2];

        // output driver, enable is active low at the pin
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                pin_o_reg[p] <= 1'b0;
                oe_n_reg[p]  <= 1'b1;
            end else begin
                pin_o_reg[p] <= src[p];
                oe_n_reg[p]  <= ~pad_reg[p][`HPCFG_BIT_OUT_EN];
            end
        end

        // input driver gates the pin towards the core
        always_ff @(posedge clk_sys) begin
            if (rst) in_reg[p] <= 1'b0;
            else in_reg[p] <= pin_i[p] & pad_reg[p][`HPCFG_BIT_IN_EN];
        end
    end

    // interrupt unit output drives the interrupt pin in place of the core when bit 16 is set
    assign src[0] = gpio_out[0];
    assign src[1] = pad_reg[1][`HPCFG_BIT_IRQ_ROUTE] ? irq_unit_out : gpio_out[1];
    assign src[2] = gpio_out[2];

    // ----------------------------------------------------------------
    // Supply-loss arming
    // ----------------------------------------------------------------

    // Slow oscillator edge, input already synchronous
    always_ff @(posedge clk_sys) begin
        if (rst) lfo_prev_reg <= 1'b0;
        else lfo_prev_reg <= low_freq_osc;
    end
    assign lfo_rise  = low_freq_osc & ~lfo_prev_reg;

    assign wr_arm    = wr_stb && addr == `HPCFG_OFS_ARM;
    assign wr_disarm = wr_stb && addr == `HPCFG_OFS_DISARM;

    hpcfg_seq #(
        .MIN_LFO_CYCLES(MIN_LFO_CYCLES)
    ) u_arm (
        .clk_sys (clk_sys),
        .rst     (rst),
        .wr_one  (wr_arm && wr_data[0]),
        .wr_zero (wr_arm && !wr_data[0]),
        .lfo_rise(lfo_rise),
        .bit_q   (supply_loss_arm_bit),
        .ready   (arm_ready),
        .done    (arm_done)
    );

    hpcfg_seq #(
        .MIN_LFO_CYCLES(MIN_LFO_CYCLES)
    ) u_disarm (
        .clk_sys (clk_sys),
        .rst     (rst),
        .wr_one  (wr_disarm && wr_data[0]),
        .wr_zero (wr_disarm && !wr_data[0]),
        .lfo_rise(lfo_rise),
        .bit_q   (supply_loss_disarm_bit),
        .ready   (disarm_ready),
        .done    (disarm_done)
    );

    // detection state, arming wins on a tie
    always_ff @(posedge clk_sys) begin
        if (rst) det_on_reg <= 1'b0;
        else if (arm_done) det_on_reg <= 1'b1;
        else if (disarm_done) det_on_reg <= 1'b0;
    end

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------

    // unused bits are zero by masking and zero-fill
    always_comb begin
        rd_next = 32'h0000_0000;
        case (addr)
            `HPCFG_OFS_DISARM: rd_next = {31'h0000_0000, supply_loss_disarm_bit};
            `HPCFG_OFS_ARM:    rd_next = {31'h0000_0000, supply_loss_arm_bit};
            `HPCFG_OFS_DL_PAD: rd_next = pad_reg[0];
            `HPCFG_OFS_IRQ_PAD: rd_next = pad_reg[1];
            `HPCFG_OFS_HD_PAD: rd_next = pad_reg[2];
            `HPCFG_OFS_STATUS: rd_next = {29'h0000_0000, disarm_ready, arm_ready, det_on_reg};
            default:           rd_next = 32'h0000_0000;
        endcase
    end

    // Data stands only in the cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (rst) rd_reg <= 32'h0000_0000;
        else if (rd_stb) rd_reg <= rd_next;
        else rd_reg <= 32'h0000_0000;
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign rd_data                   = rd_reg;
    assign supply_loss_det_on        = det_on_reg;
    assign gpio_in                   = in_reg;
    assign download_request_pin_o    = pin_o_reg[0];
    assign download_request_pin_oe_n = oe_n_reg[0];
    assign interrupt_pin_o           = pin_o_reg[1];
    assign interrupt_pin_oe_n        = oe_n_reg[1];
    assign host_data_pin_o           = pin_o_reg[2];
    assign host_data_pin_oe_n        = oe_n_reg[2];

    // Field views of the pad registers
    assign download_drive_sel  = pad_reg[0][`HPCFG_LSB_DRIVE+:2];
    assign interrupt_drive_sel = pad_reg[1][`HPCFG_LSB_DRIVE+:2];
    assign host_data_drive_sel = pad_reg[2][`HPCFG_LSB_DRIVE+:2];
    assign download_pull_sel   = pad_reg[0][`HPCFG_LSB_PULL+:2];
    assign interrupt_pull_sel  = pad_reg[1][`HPCFG_LSB_PULL+:2];
    assign host_data_pull_sel  = pad_reg[2][`HPCFG_LSB_PULL+:2];
    assign download_out_en     = pad_reg[0][`HPCFG_BIT_OUT_EN];
    assign download_in_en      = pad_reg[0][`HPCFG_BIT_IN_EN];
    assign interrupt_out_en    = pad_reg[1][`HPCFG_BIT_OUT_EN];
    assign interrupt_in_en     = pad_reg[1][`HPCFG_BIT_IN_EN];
    assign host_data_out_en    = pad_reg[2][`HPCFG_BIT_OUT_EN];
    assign host_data_in_en     = pad_reg[2][`HPCFG_BIT_IN_EN];
    assign interrupt_route     = pad_reg[1][`HPCFG_BIT_IRQ_ROUTE];

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------

    // Documented values right after reset
    pad_reset_vals_a: assert property (@(posedge clk_sys)
        $past(rst) && !rst |-> pad_reg[0] == 32'h0000_0000 && pad_reg[1] == 32'h0000_0000
                               && pad_reg[2] == 32'h0000_000d && host_data_pull_sel == 2'h3
                               && interrupt_pull_sel == 2'h0)
        else $error("pad register reset value wrong");

    // Output enable follows the driver bit one cycle later
    out_enable_follow_a: assert property (@(posedge clk_sys) disable iff (rst)
        !$past(rst) |-> download_request_pin_oe_n == !$past(download_out_en)
                        && host_data_pin_oe_n == !$past(host_data_out_en))
        else $error("pin output enable does not follow driver bit");

    // Input reaches the core only when enabled
    in_driver_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
        !$past(rst) |-> gpio_in[2] == ($past(host_data_pin_i) && $past(host_data_in_en))
                        && gpio_in[0] == ($past(download_request_pin_i) && $past(download_in_en)))
        else $error("input driver gating wrong");

    // Exactly the decoded pull control per code
    pull_decode_map_a: assert property (@(posedge clk_sys) disable iff (rst)
        pad_pull_up[2] == (host_data_pull_sel == 2'h3) && pad_keeper[1] == (interrupt_pull_sel == 2'h2)
        && pad_pull_down[0] == (download_pull_sel == 2'h0))
        else $error("pull decode wrong");

    // Interrupt pin data source
    irq_route_src_a: assert property (@(posedge clk_sys) disable iff (rst)
        !$past(rst) |-> interrupt_pin_o == ($past(interrupt_route) ? $past(irq_unit_out)
                                                                  : $past(gpio_out[1])))
        else $error("interrupt pin source wrong");

    // Reserved bits of a read are zero
    reserved_read_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
        $past(rd_stb) && $past(addr) == `HPCFG_OFS_IRQ_PAD |-> (rd_data & ~`HPCFG_MASK_IRQ_PAD) == '0)
        else $error("reserved bits read nonzero");

    // Drive selection takes the written value
    drive_sel_write_a: assert property (@(posedge clk_sys) disable iff (rst)
        wr_stb && addr == `HPCFG_OFS_DL_PAD |=> download_drive_sel == $past(wr_data[5:4]))
        else $error("drive selection not written");

    // Detection changes only through a completed sequence
    det_state_cause_a: assert property (@(posedge clk_sys) disable iff (rst)
        ($rose(det_on_reg) |-> $past(arm_done)) and ($fell(det_on_reg) |-> $past(disarm_done)))
        else $error("detection state changed without a sequence");

endmodule : hpcfg_top
`default_nettype wire

// File: test/hpcfg_top_bench.sv
// Self-checking bench for the host pad configuration registers
`timescale 1ns/1ns
`default_nettype none
`include "hpcfg_defs.svh"

module hpcfg_top_bench;

    // ----------------------------------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------------------------------
    logic        clk_sys;
    logic        rst;
    logic [7:0]  addr;
    logic [31:0] wr_data;
    logic        wr_stb;
    logic        rd_stb;
    logic [31:0] rd_data;
    logic        low_freq_osc;
    logic        arm_bit;
    logic        disarm_bit;
    logic        det_on;
    logic [2:0]  gpio_out;
    logic [2:0]  gpio_in;
    logic        irq_unit_out;
    logic [2:0]  pin_i;
    wire  [2:0]  pin_o;
    wire  [2:0]  oe_n;
    wire  [5:0]  drv;
    wire  [5:0]  pull;
    wire  [2:0]  p_down;
    wire  [2:0]  p_up;
    wire  [2:0]  p_keep;
    int          n_fail;
    int          num_checks;
    logic [7:0]  pad_ofs [3];

    // ----------------------------------------------------------------
    // Device under test; pad index 0 download, 1 interrupt, 2 host data
    // ----------------------------------------------------------------
    hpcfg_top hpcfg_top_i (
        .clk_sys(clk_sys), .rst(rst), .addr(addr), .wr_data(wr_data),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
        .low_freq_osc(low_freq_osc), .supply_loss_arm_bit(arm_bit),
        .supply_loss_disarm_bit(disarm_bit), .supply_loss_det_on(det_on),
        .gpio_out(gpio_out), .gpio_in(gpio_in), .irq_unit_out(irq_unit_out),
        .download_request_pin_i(pin_i[0]), .download_request_pin_o(pin_o[0]),
        .download_request_pin_oe_n(oe_n[0]),
        .interrupt_pin_i(pin_i[1]), .interrupt_pin_o(pin_o[1]),
        .interrupt_pin_oe_n(oe_n[1]),
        .host_data_pin_i(pin_i[2]), .host_data_pin_o(pin_o[2]),
        .host_data_pin_oe_n(oe_n[2]),
        .download_drive_sel(drv[1:0]), .interrupt_drive_sel(drv[3:2]),
        .host_data_drive_sel(drv[5:4]),
        .download_pull_sel(pull[1:0]), .interrupt_pull_sel(pull[3:2]),
        .host_data_pull_sel(pull[5:4]),
        .pad_pull_down(p_down), .pad_pull_up(p_up), .pad_keeper(p_keep),
        .download_out_en(), .download_in_en(), .interrupt_out_en(),
        .interrupt_in_en(), .host_data_out_en(), .host_data_in_en(),
        .interrupt_route()
    );

    // ----------------------------------------------------------------
    // Access and compare tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // One-cycle write strobe, dropped at the next edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr    <= a;
        wr_data <= d;
        wr_stb  <= 1'b1;
        @(posedge clk_sys);
        wr_stb  <= 1'b0;
        // Fields update on this edge; look only once they have settled
        #1;
    endtask : wr

    // Read data is sampled only in the cycle after the strobe
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge clk_sys);
        rd_stb <= 1'b0;
        #1;
        chk(rd_data, exp);
    endtask : rdc

    // Let one more edge land before sampling registered outputs
    task automatic settle;
        @(posedge clk_sys);
        #1;
    endtask : settle

    // Slow oscillator as a level, several system cycles per phase
    task automatic lfo_rises(input int n);
        repeat (n) begin
            repeat (3) @(posedge clk_sys);
            low_freq_osc <= 1'b1;
            repeat (3) @(posedge clk_sys);
            low_freq_osc <= 1'b0;
        end
    endtask : lfo_rises

    task automatic report_and_stop;
        if (n_fail == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop

    // ----------------------------------------------------------------
    // Clock, watchdog and test sequence
    // ----------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Whole sequence needs well under a thousand cycles
    initial begin
        #100000;
        n_fail++;
        report_and_stop();
    end

    initial begin
        rst = 1'b1; addr = 8'h00; wr_data = 32'h0000_0000; wr_stb = 1'b0;
        rd_stb = 1'b0; low_freq_osc = 1'b0; gpio_out = 3'h0;
        irq_unit_out = 1'b0; pin_i = 3'h7; n_fail = 0; num_checks = 0;
        pad_ofs = '{`HPCFG_OFS_DL_PAD, `HPCFG_OFS_IRQ_PAD, `HPCFG_OFS_HD_PAD};
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        // Reset values of the pad registers
        rdc(`HPCFG_OFS_DL_PAD, 32'h0000_0000);
        rdc(`HPCFG_OFS_IRQ_PAD, 32'h0000_0000);
        rdc(`HPCFG_OFS_HD_PAD, 32'h0000_000d);
        chk(pull, 6'h30);
        chk(gpio_in, 3'h4);
        chk(det_on, 1'b0);
        // Reserved bits, unmapped place
        foreach (pad_ofs[p]) wr(pad_ofs[p], 32'hffff_ffff);
        rdc(`HPCFG_OFS_DL_PAD, 32'h0000_003f);
        rdc(`HPCFG_OFS_IRQ_PAD, 32'h0001_003f);
        rdc(`HPCFG_OFS_HD_PAD, 32'h0000_003f);
        chk(drv, 6'h3f);
        wr(8'h10, 32'hffff_ffff);
        rdc(8'h10, 32'h0000_0000);
        rdc(`HPCFG_OFS_DL_PAD, 32'h0000_003f);
        // every pull code on every pad
        for (int c = 0; c < 4; c++) begin
            foreach (pad_ofs[p]) wr(pad_ofs[p], 32'(c) << 2);
            chk(pull, {3{c[1:0]}});
            chk({p_down, p_keep, p_up}, {{3{c == 0}}, {3{c == 2}}, {3{c == 3}}});
            chk(drv, 6'h00);
        end
        // input drivers gate the pin levels
        foreach (pad_ofs[p]) wr(pad_ofs[p], 32'h0000_0001);
        settle();
        chk(gpio_in, 3'h7);
        wr(`HPCFG_OFS_HD_PAD, 32'h0000_0000);
        settle();
        chk(gpio_in, 3'h3);
        gpio_out <= 3'h7;
        foreach (pad_ofs[p]) wr(pad_ofs[p], 32'h0000_0002);
        settle();
        chk({oe_n, pin_o}, 6'h07);
        wr(`HPCFG_OFS_IRQ_PAD, 32'h0001_0002);
        settle();
        chk(pin_o, 3'h5);
        @(posedge clk_sys);
        irq_unit_out <= 1'b1;
        settle();
        chk(pin_o, 3'h7);
        foreach (pad_ofs[p]) wr(pad_ofs[p], 32'h0000_0000);
        settle();
        chk(oe_n, 3'h7);
        // zero too early, then after one rise only, then qualified
        wr(`HPCFG_OFS_ARM, 32'h0000_0001);
        chk(arm_bit, 1'b1);
        wr(`HPCFG_OFS_ARM, 32'h0000_0000);
        settle();
        settle();
        chk(det_on, 1'b0);
        wr(`HPCFG_OFS_ARM, 32'h0000_0001);
        lfo_rises(1);
        wr(`HPCFG_OFS_ARM, 32'h0000_0000);
        settle();
        chk(det_on, 1'b0);
        wr(`HPCFG_OFS_ARM, 32'h0000_0001);
        lfo_rises(2);
        wr(`HPCFG_OFS_ARM, 32'h0000_0000);
        settle();
        chk(det_on, 1'b1);
        wr(`HPCFG_OFS_DISARM, 32'h0000_0001);
        chk({disarm_bit, det_on}, 2'h3);
        lfo_rises(2);
        rdc(`HPCFG_OFS_STATUS, 32'h0000_0005);
        rdc(`HPCFG_OFS_DISARM, 32'h0000_0001);
        wr(`HPCFG_OFS_DISARM, 32'h0000_0000);
        settle();
        chk(det_on, 1'b0);
        rdc(`HPCFG_OFS_STATUS, 32'h0000_0000);
        rdc(`HPCFG_OFS_ARM, 32'h0000_0000);
        report_and_stop();
    end

endmodule : hpcfg_top_bench
`default_nettype wire
